// >>> rtl/dtc_pkg.sv
package dtc_pkg;
	// ----------------------------------------------------------------
	// register map (printed offsets are not multiples of four: indices)
	// ----------------------------------------------------------------
	localparam logic [19:0] DTC_IDX_CH0_FILT = 20'h0_f026a;
	localparam logic [19:0] DTC_IDX_CH1_FILT = 20'h0_f026b;
	localparam logic [19:0] DTC_IDX_CH0_CCC = 20'h0_f0270;
	localparam logic [19:0] DTC_IDX_CH1_CCC = 20'h0_f0280;
	localparam logic [19:0] DTC_IDX_CTRL = 20'h0_f0290;
	localparam logic [19:0] DTC_IDX_STAT = 20'h0_f0291;
	localparam logic [7:0] DTC_RST_REG = 8'h00;
	// ----------------------------------------------------------------
	// field codes
	// ----------------------------------------------------------------
	localparam logic [1:0] DTC_FCK_DIV32 = 2'h0;
	localparam logic [1:0] DTC_FCK_DIV8 = 2'h1;
	localparam logic [1:0] DTC_FCK_DIV1 = 2'h2;
	localparam logic [1:0] DTC_FCK_SRC = 2'h3;
	localparam logic [1:0] DTC_CUT_OFF = 2'h0;
	localparam logic [1:0] DTC_CUT_HIZ = 2'h1;
	localparam logic [1:0] DTC_CUT_LOW = 2'h2;
	localparam logic [1:0] DTC_CUT_HIGH = 2'h3;
	localparam logic [2:0] DTC_CLR_FREE = 3'h0;
	localparam logic [2:0] DTC_CLR_A = 3'h1;
	localparam logic [2:0] DTC_CLR_B = 3'h2;
	localparam logic [2:0] DTC_CLR_SYNC = 3'h3;
	localparam logic [2:0] DTC_CLR_C = 3'h5;
	localparam logic [2:0] DTC_CLR_D = 3'h6;
	localparam logic [1:0] DTC_EDGE_RISE = 2'h0;
	localparam logic [1:0] DTC_EDGE_FALL = 2'h1;
	localparam logic [1:0] DTC_EDGE_BOTH = 2'h2;
	localparam logic [2:0] DTC_SRC_DIV1 = 3'h0;
	localparam logic [2:0] DTC_SRC_DIV2 = 3'h1;
	localparam logic [2:0] DTC_SRC_DIV4 = 3'h2;
	localparam logic [2:0] DTC_SRC_DIV8 = 3'h3;
	localparam logic [2:0] DTC_SRC_DIV32 = 3'h4;
	localparam logic [2:0] DTC_SRC_EXT = 3'h5;
	// control register bit positions
	localparam int DTC_CTRL_EXTEN = 0;
	localparam int DTC_CTRL_SYNC = 1;
	localparam int DTC_CTRL_PWM = 2;
	localparam int DTC_CTRL_RSPWM = 3;
	localparam int DTC_CTRL_PWM3 = 4;
	localparam int DTC_CTRL_START = 5;
	// filter: edge accepted after this many matching samples
	localparam int DTC_FILT_SAMPLES = 3;
	localparam logic [2:0] DTC_FILT_CNT_MAX = 3'(DTC_FILT_SAMPLES);
	localparam logic [4:0] DTC_PRE_MAX = 5'h1f;
	localparam logic [15:0] DTC_CNT_RST = 16'h0000;
	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] fck;
		logic [1:0] cut_b;
		logic en_d;
		logic en_c;
		logic en_b;
		logic en_a;
	} dtc_filt_t;
	typedef struct packed {
		logic [2:0] clr;
		logic [1:0] edge_sel;
		logic [2:0] src;
	} dtc_ccc_t;
	typedef struct packed {
		logic [3:0] oe_n;
		logic [3:0] lvl;
	} dtc_pins_t;
endpackage : dtc_pkg

// >>> rtl/dtc_top.sv
// Strobed register access was decided locally.
`timescale 1ns/100ps
// What this block does
// - enabled filter recognises a pin edge within five filter sampling clocks.
// - filter enable bit 1 turns on the capture pin's digital filter.
// - filter clock field: 00 div32, 01 div8, 10 undivided, 11 count source.
// - with oscillator option set, those filter clocks come from the oscillator.
// - cutoff field: 00 disabled, 01 high impedance, 10 low, 11 high.
// - in PWM modes filter bits become cutoff fields for pins A, B, C, D.
// - channel 1 control is ignored in reset-synchronous and three-phase PWM modes.
// - clear select picks free run, A, B, sync, C or D; others prohibited.
// - synchronous clear acts only when the channel sync bit is 1.
// - external edge: 00 rising, 01 falling, 10 both, 11 prohibited.
// - edge select applies only with source 101 and external clock enable set.
// - source 000 is system clock, or the oscillator when the option is set.
// - source 101 is the external pin, valid only with external clock enable.
// - reset contents are defined only with the peripheral clock running.
module dtc_top
	import dtc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [19:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic osc_select_option,
	input wire logic timer_periph_clock_en,
	input wire logic osc_tick,
	input wire logic ext_count_clock_pin,
	input wire logic [7:0] timer_pin_in,
	input wire logic [7:0] capture_match,
	input wire logic [7:0] wave_out,
	input wire logic cutoff_event,
	output logic [1:0] count_tick,
	output logic [1:0] counter_clear,
	output logic [7:0] filtered_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe_n
);
	// ----------------------------------------------------------------
	// registers and bus slave
	// ----------------------------------------------------------------
	dtc_filt_t filt_q [2];
	dtc_ccc_t ccc_q [2];
	logic [7:0] ctrl_q;
	logic [7:0] stat_q;
	logic [7:0] rdata_q;
	logic pwm_any;
	logic ch1_ignored;

	// reset-sync and three-phase modes share channel 0 clocking
	assign pwm_any = ctrl_q[DTC_CTRL_PWM] | ctrl_q[DTC_CTRL_RSPWM] | ctrl_q[DTC_CTRL_PWM3];
	assign ch1_ignored = ctrl_q[DTC_CTRL_RSPWM] | ctrl_q[DTC_CTRL_PWM3];

	// register writes; only held in reset, software gates clocks around us
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			filt_q[0] <= dtc_filt_t'(DTC_RST_REG);
			filt_q[1] <= dtc_filt_t'(DTC_RST_REG);
			ccc_q[0] <= dtc_ccc_t'(DTC_RST_REG);
			ccc_q[1] <= dtc_ccc_t'(DTC_RST_REG);
			ctrl_q <= DTC_RST_REG;
		end else if (reg_wr) begin
			case (reg_addr)
				DTC_IDX_CH0_FILT: filt_q[0] <= dtc_filt_t'(reg_wdata);
				DTC_IDX_CH1_FILT: filt_q[1] <= dtc_filt_t'(reg_wdata);
				DTC_IDX_CH0_CCC: ccc_q[0] <= dtc_ccc_t'(reg_wdata);
				DTC_IDX_CH1_CCC: ccc_q[1] <= dtc_ccc_t'(reg_wdata);
				DTC_IDX_CTRL: ctrl_q <= reg_wdata;
				default: ;
			endcase
		end
	end

	// read data valid the cycle after the strobe; unmapped reads zero
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rdata_q <= DTC_RST_REG;
		end else if (reg_rd) begin
			case (reg_addr)
				DTC_IDX_CH0_FILT: rdata_q <= filt_q[0];
				DTC_IDX_CH1_FILT: rdata_q <= filt_q[1];
				DTC_IDX_CH0_CCC: rdata_q <= ccc_q[0];
				DTC_IDX_CH1_CCC: rdata_q <= ccc_q[1];
				DTC_IDX_CTRL: rdata_q <= ctrl_q;
				DTC_IDX_STAT: rdata_q <= stat_q;
				default: rdata_q <= DTC_RST_REG;
			endcase
		end else begin
			rdata_q <= DTC_RST_REG;
		end
	end
	assign reg_rdata = rdata_q;

	// ----------------------------------------------------------------
	// prescaler: one tick source for system clock or oscillator
	// ----------------------------------------------------------------
	logic [4:0] pre_q;
	logic base_tick;
	logic div2, div4, div8, div32;

	// oscillator option reroutes the base tick to the oscillator enable
	assign base_tick = osc_select_option ? osc_tick : 1'b1;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pre_q <= 5'h00;
		end else if (base_tick) begin
			pre_q <= pre_q + 5'h01;
		end
	end
	assign div2 = base_tick & (pre_q[0] == 1'b1);
	assign div4 = base_tick & (pre_q[1:0] == 2'h3);
	assign div8 = base_tick & (pre_q[2:0] == 3'h7);
	assign div32 = base_tick & (pre_q == DTC_PRE_MAX);

	// ----------------------------------------------------------------
	// external clock pin: three-stage synchroniser, edge detection
	// ----------------------------------------------------------------
	logic [2:0] ext_sync_q;
	logic ext_lvl_q;
	logic ext_rise, ext_fall;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ext_sync_q <= 3'h0;
			ext_lvl_q <= 1'b0;
		end else begin
			ext_sync_q <= {ext_sync_q[1:0], ext_count_clock_pin};
			// accept a new level only once stages two and three agree
			if (ext_sync_q[1] == ext_sync_q[2]) begin
				ext_lvl_q <= ext_sync_q[2];
			end
		end
	end
	assign ext_rise = (ext_sync_q[1] == ext_sync_q[2]) & ext_sync_q[2] & ~ext_lvl_q;
	assign ext_fall = (ext_sync_q[1] == ext_sync_q[2]) & ~ext_sync_q[2] & ext_lvl_q;

	// ----------------------------------------------------------------
	// per-channel count source, clear and filter clock
	// ----------------------------------------------------------------
	logic [1:0] src_tick;
	logic [1:0] filt_tick;
	logic [1:0] clr_raw;
	dtc_ccc_t ccc_eff [2];
	dtc_filt_t filt_eff [2];

	// channel 1 follows channel 0 where its own control is ignored
	assign ccc_eff[0] = ccc_q[0];
	assign ccc_eff[1] = ch1_ignored ? ccc_q[0] : ccc_q[1];
	assign filt_eff[0] = filt_q[0];
	assign filt_eff[1] = filt_q[1];

	always_comb begin
		for (int c = 0; c < 2; c++) begin
			src_tick[c] = 1'b0;
			case (ccc_eff[c].src)
				DTC_SRC_DIV1: src_tick[c] = base_tick;
				DTC_SRC_DIV2: src_tick[c] = div2;
				DTC_SRC_DIV4: src_tick[c] = div4;
				DTC_SRC_DIV8: src_tick[c] = div8;
				DTC_SRC_DIV32: src_tick[c] = div32;
				DTC_SRC_EXT: begin
					// pin only counts with the external enable set
					if (ctrl_q[DTC_CTRL_EXTEN]) begin
						case (ccc_eff[c].edge_sel)
							DTC_EDGE_RISE: src_tick[c] = ext_rise;
							DTC_EDGE_FALL: src_tick[c] = ext_fall;
							DTC_EDGE_BOTH: src_tick[c] = ext_rise | ext_fall;
							default: src_tick[c] = 1'b0; // prohibited code never counts
						endcase
					end
				end
				default: src_tick[c] = 1'b0; // prohibited source
			endcase
			filt_tick[c] = 1'b0;
			case (filt_eff[c].fck)
				DTC_FCK_DIV32: filt_tick[c] = div32;
				DTC_FCK_DIV8: filt_tick[c] = div8;
				DTC_FCK_DIV1: filt_tick[c] = base_tick;
				DTC_FCK_SRC: filt_tick[c] = src_tick[c];
				default: filt_tick[c] = 1'b0;
			endcase
			clr_raw[c] = 1'b0;
			case (ccc_eff[c].clr)
				DTC_CLR_FREE: clr_raw[c] = 1'b0;
				DTC_CLR_A: clr_raw[c] = capture_match[4*c+0];
				DTC_CLR_B: clr_raw[c] = capture_match[4*c+1];
				DTC_CLR_C: clr_raw[c] = capture_match[4*c+2];
				DTC_CLR_D: clr_raw[c] = capture_match[4*c+3];
				default: clr_raw[c] = 1'b0; // sync handled below, others prohibited
			endcase
		end
	end

	// counts only while started; source changes take effect at once, even while running
	assign count_tick = ctrl_q[DTC_CTRL_START] ? src_tick : 2'b00;

	// sync clear mirrors the other channel's clear when the sync bit is set
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			counter_clear[c] = clr_raw[c];
			if (ccc_eff[c].clr == DTC_CLR_SYNC && ctrl_q[DTC_CTRL_SYNC]) begin
				counter_clear[c] = clr_raw[1-c];
			end
		end
	end

	// ----------------------------------------------------------------
	// input digital filter, one per capture pin
	// ----------------------------------------------------------------
	logic [7:0] filt_en;
	logic [7:0] pin_s1_q, pin_s2_q, pin_s3_q;
	logic [7:0] filt_out_q;
	logic [2:0] filt_cnt_q [8];

	// filter disabled in PWM modes where its bits mean cutoff
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			filt_en[4*c+0] = filt_eff[c].en_a & ~pwm_any;
			filt_en[4*c+1] = filt_eff[c].en_b & ~pwm_any;
			filt_en[4*c+2] = filt_eff[c].en_c & ~pwm_any;
			filt_en[4*c+3] = filt_eff[c].en_d & ~pwm_any;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pin_s1_q <= 8'h00;
			pin_s2_q <= 8'h00;
			pin_s3_q <= 8'h00;
		end else begin
			pin_s1_q <= timer_pin_in;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	// three equal samples accept a level: edge seen within five samples
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			filt_out_q <= 8'h00;
			for (int p = 0; p < 8; p++) begin
				filt_cnt_q[p] <= 3'h0;
			end
		end else begin
			for (int p = 0; p < 8; p++) begin
				if (pin_s2_q[p] != pin_s3_q[p]) begin
					filt_cnt_q[p] <= filt_cnt_q[p]; // unsettled, hold
				end else if (!filt_en[p]) begin
					filt_out_q[p] <= pin_s3_q[p];
					filt_cnt_q[p] <= 3'h0;
				end else if (pin_s3_q[p] == filt_out_q[p]) begin
					filt_cnt_q[p] <= 3'h0;
				end else if (filt_tick[p/4]) begin
					if (filt_cnt_q[p] == DTC_FILT_CNT_MAX - 3'h1) begin
						filt_out_q[p] <= pin_s3_q[p];
						filt_cnt_q[p] <= 3'h0;
					end else begin
						filt_cnt_q[p] <= filt_cnt_q[p] + 3'h1;
					end
				end
			end
		end
	end
	assign filtered_in = filt_out_q;

	// ----------------------------------------------------------------
	// forced cutoff of the waveform outputs
	// ----------------------------------------------------------------
	logic cut_q;
	logic [1:0] cut_fld [8];
	logic [7:0] pout_q, poe_n_q;

	// latched until software stops the counter
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cut_q <= 1'b0;
		end else if (cutoff_event) begin
			cut_q <= 1'b1;
		end else if (!ctrl_q[DTC_CTRL_START]) begin
			cut_q <= 1'b0;
		end
	end

	always_comb begin
		for (int c = 0; c < 2; c++) begin
			cut_fld[4*c+0] = filt_eff[c].fck;
			cut_fld[4*c+1] = filt_eff[c].cut_b;
			cut_fld[4*c+2] = {filt_eff[c].en_d, filt_eff[c].en_c};
			cut_fld[4*c+3] = {filt_eff[c].en_b, filt_eff[c].en_a};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pout_q <= 8'h00;
			poe_n_q <= 8'hff;
		end else begin
			for (int p = 0; p < 8; p++) begin
				pout_q[p] <= wave_out[p];
				poe_n_q[p] <= ~pwm_any;
				if (pwm_any && (cut_q || cutoff_event) && cut_fld[p] != DTC_CUT_OFF) begin
					case (cut_fld[p])
						DTC_CUT_HIZ: begin
							pout_q[p] <= 1'b0;
							poe_n_q[p] <= 1'b1;
						end
						DTC_CUT_LOW: pout_q[p] <= 1'b0;
						DTC_CUT_HIGH: pout_q[p] <= 1'b1;
						default: pout_q[p] <= wave_out[p];
					endcase
				end
			end
		end
	end
	assign pin_out = pout_q;
	assign pin_oe_n = poe_n_q;

	// status: cutoff latched, external level, filtered pins of channel 0
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			stat_q <= DTC_RST_REG;
		end else begin
			stat_q <= {cut_q, ext_lvl_q, timer_periph_clock_en, 1'b0, filt_out_q[3:0]};
		end
	end
endmodule : dtc_top

// >>> sim/dtc_far_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// far side: external count clock and the two-way timer pins
// ------------------------------------------------------------
module dtc_far_model (
	input wire logic ref_clk,
	input wire logic ext_go,
	input wire logic [7:0] pin_drive,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_n,
	output logic ext_clk,
	output logic [7:0] pin_wire
);
	logic [6:0] run_q = 7'h00;
	initial ext_clk = 1'b0;
	// one burst of eight periods; parked low between bursts, like a gated source
	// plain always: ext_clk also takes a start value from the initial block
	always @(posedge ref_clk) begin
		if (ext_go) run_q <= 7'h40;
		else if (run_q != 7'h00) run_q <= run_q - 7'h01;
		if (run_q != 7'h00 && run_q[1:0] == 2'h1) ext_clk <= ~ext_clk;
	end
	// wire level: the block wins wherever its enable is low
	assign pin_wire = (pin_oe_n & pin_drive) | (~pin_oe_n & pin_out);
endmodule : dtc_far_model

// >>> sim/dtc_top_asserts.sv
`timescale 1ns/100ps
module dtc_top_asserts
	import dtc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [19:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic osc_select_option,
	input wire logic [7:0] timer_pin_in,
	input wire logic [7:0] capture_match,
	input wire logic cutoff_event,
	input wire logic [1:0] count_tick,
	input wire logic [1:0] counter_clear,
	input wire logic [7:0] filtered_in,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_n
);
	logic [7:0] ctl_q;
	logic [7:0] ccc_q;
	logic [7:0] flt_q;
	logic run;
	logic sys;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// shadow of the registers the checks lean on, taken from bus writes
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctl_q <= 8'h00;
			ccc_q <= 8'h00;
			flt_q <= 8'h00;
		end else if (reg_wr) begin
			if (reg_addr == DTC_IDX_CTRL) ctl_q <= reg_wdata;
			if (reg_addr == DTC_IDX_CH0_CCC) ccc_q <= reg_wdata;
			if (reg_addr == DTC_IDX_CH0_FILT) flt_q <= reg_wdata;
		end
	end
	assign run = ctl_q[DTC_CTRL_START];
	assign sys = run && ccc_q[2:0] == DTC_SRC_DIV1 && !osc_select_option;
	sequence s_cut;
		cutoff_event && run && ctl_q[DTC_CTRL_PWM];
	endsequence
	sequence s_quiet;
		(!flt_q[0] && ctl_q[4:2] == 3'h0) [*5];
	endsequence
	sequence s_rise;
		$rose(timer_pin_in[0]) && flt_q[0] && flt_q[7:6] == DTC_FCK_DIV1 && ctl_q[4:2] == 3'h0
			&& !osc_select_option ##1 timer_pin_in[0] [*8];
	endsequence
	property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
	property p_rd_back; reg_rd && reg_addr == DTC_IDX_CH0_CCC |=> reg_rdata == $past(ccc_q); endproperty
	property p_no_tick; !run |-> count_tick == 2'b00; endproperty
	property p_src_sys; sys |-> count_tick[0]; endproperty
	property p_rs_ch1; sys && ctl_q[DTC_CTRL_RSPWM] |-> count_tick[1]; endproperty
	property p_clr_a; run && ccc_q[7:5] == DTC_CLR_A && capture_match[0] |-> counter_clear[0]; endproperty
	property p_clr_free; ccc_q[7:5] == DTC_CLR_FREE |-> !counter_clear[0]; endproperty
	property p_cut_hiz; s_cut ##0 flt_q[7:6] == DTC_CUT_HIZ |=> pin_oe_n[0]; endproperty
	property p_cut_drv; s_cut ##0 flt_q[7] |=> !pin_oe_n[0] && pin_out[0] == $past(flt_q[6]); endproperty
	property p_filt_off; s_quiet |-> filtered_in[0] == $past(timer_pin_in[0], 4); endproperty
	property p_filt_on; s_rise |-> ##[0:3] filtered_in[0]; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
	a_rd_back: assert property (p_rd_back) else $error("read back differs");
	a_no_tick: assert property (p_no_tick) else $error("tick while stopped");
	a_src_sys: assert property (p_src_sys) else $error("no tick from system clock");
	a_rs_ch1: assert property (p_rs_ch1) else $error("channel 1 not slaved");
	a_clr_a: assert property (p_clr_a) else $error("no clear on match A");
	a_clr_free: assert property (p_clr_free) else $error("clear in free run");
	a_cut_hiz: assert property (p_cut_hiz) else $error("cutoff pin still driven");
	a_cut_drv: assert property (p_cut_drv) else $error("cutoff level wrong");
	a_filt_off: assert property (p_filt_off) else $error("unfiltered path delay");
	a_filt_on: assert property (p_filt_on) else $error("filtered edge too late");
endmodule : dtc_top_asserts

// >>> sim/dual_timer_clock_clear_cutoff_test.sv
`timescale 1ns/100ps
module dual_timer_clock_clear_cutoff_test import dtc_pkg::*;;
	logic ref_clk, rst, reg_wr, reg_rd, osc, oscp, go, cev, ext;
	logic [19:0] addr;
	logic [7:0] wd, rdata, cm, wave, drv, pw, fin, pout, poe;
	logic [1:0] tick, clr;
	int mismatches, checked, cyc;
	int exp_reg[4];
	logic [19:0] map[4] = '{DTC_IDX_CH0_FILT, DTC_IDX_CH1_FILT, DTC_IDX_CH0_CCC, DTC_IDX_CH1_CCC};
	logic [2:0] clrs[4] = '{DTC_CLR_A, DTC_CLR_B, DTC_CLR_C, DTC_CLR_D};
	int sh[5] = '{0, 1, 2, 3, 5};
	logic [7:0] pats[2] = '{8'h6c, 8'hd9};
	dtc_top dut_u (.ref_clk(ref_clk), .rst(rst), .reg_addr(addr), .reg_wdata(wd), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(rdata), .osc_select_option(osc), .timer_periph_clock_en(1'b1),
		.osc_tick(oscp), .ext_count_clock_pin(ext), .timer_pin_in(pw), .capture_match(cm), .wave_out(wave),
		.cutoff_event(cev), .count_tick(tick), .counter_clear(clr), .filtered_in(fin), .pin_out(pout),
		.pin_oe_n(poe));
	dtc_far_model far_u (.ref_clk(ref_clk), .ext_go(go), .pin_drive(drv), .pin_out(pout), .pin_oe_n(poe),
		.ext_clk(ext), .pin_wire(pw));
	// ------------------------------------------------------------
	// bus and checking tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [19:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		addr <= a;
		wd <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [19:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask : rd
	// ticks seen on one channel; e counts the oscillator pulses offered
	task automatic cnt(input int n, input int ch, output int c, output int e);
		c = 0;
		e = 0;
		repeat (n) begin
			@(posedge ref_clk);
			oscp <= osc && ($urandom % 3 == 0);
			@(negedge ref_clk);
			c += tick[ch];
			e += oscp;
		end
		@(posedge ref_clk);
		oscp <= 1'b0;
	endtask : cnt
	task automatic clr_chk(input logic [7:0] m, input logic [7:0] exp);
		@(posedge ref_clk);
		cm <= m;
		@(negedge ref_clk);
		chk({6'h00, clr}, exp);
		@(posedge ref_clk);
		cm <= 8'h00;
	endtask : clr_chk
	task automatic wrap_up;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : wrap_up
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// hang guard, well above the thousand or so cycles the run needs
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			wrap_up();
		end
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		int c, e, k;
		logic [7:0] f;
		{rst, reg_wr, reg_rd, osc, oscp, go, cev, addr, wd, cm, wave, drv} = {1'b1, 58'h0};
		{mismatches, checked, cyc} = '0;
		k = $urandom(95532);
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		foreach (map[i]) rd(map[i], 8'h00);
		foreach (map[i]) begin
			exp_reg[i] = $urandom % 256;
			wr(map[i], exp_reg[i][7:0]);
		end
		foreach (map[i]) rd(map[i], exp_reg[i][7:0]);
		wr(20'h0_f0000, 8'ha5);
		rd(20'h0_f0000, 8'h00);
		foreach (map[i]) wr(map[i], 8'h00);
		rd(DTC_IDX_STAT, 8'h20);
		$display("test registers done");
		wr(DTC_IDX_CTRL, 8'h20);
		for (k = 0; k < 5; k++) begin
			wr(DTC_IDX_CH0_CCC, 8'(k));
			cnt(64, 0, c, e);
			chk(8'(c), 8'(64 >> sh[k]));
		end
		osc <= 1'b1;
		wr(DTC_IDX_CH0_CCC, 8'h00);
		cnt(40, 0, c, e);
		chk(8'(c), 8'(e));
		osc <= 1'b0;
		wr(DTC_IDX_CH1_CCC, 8'h04);
		wr(DTC_IDX_CH0_CCC, {DTC_CLR_A, 5'h00});
		wr(DTC_IDX_CTRL, 8'h28);
		cnt(20, 1, c, e);
		chk(8'(c), 8'h14);
		$display("test sources done");
		for (k = 0; k < 4; k++) begin
			wr(DTC_IDX_CTRL, (k == 3) ? 8'h20 : 8'h21);
			wr(DTC_IDX_CH0_CCC, {3'h0, 2'(k % 3), DTC_SRC_EXT});
			@(posedge ref_clk);
			go <= 1'b1;
			@(posedge ref_clk);
			go <= 1'b0;
			cnt(80, 0, c, e);
			chk(8'(c), (k == 3) ? 8'h00 : (k == 2) ? 8'h10 : 8'h08);
		end
		$display("test external clock done");
		wr(DTC_IDX_CTRL, 8'h20);
		for (k = 0; k < 4; k++) begin
			wr(DTC_IDX_CH0_CCC, {clrs[k], 5'h00});
			clr_chk(8'(1 << k), 8'h01);
			clr_chk(8'(1 << ((k + 1) % 4)), 8'h00);
		end
		wr(DTC_IDX_CH0_CCC, 8'h00);
		clr_chk(8'h0f, 8'h00);
		wr(DTC_IDX_CH0_CCC, {DTC_CLR_A, 5'h00});
		wr(DTC_IDX_CH1_CCC, {DTC_CLR_SYNC, 5'h00});
		clr_chk(8'h01, 8'h01);
		wr(DTC_IDX_CTRL, 8'h22);
		clr_chk(8'h01, 8'h03);
		$display("test clear done");
		wr(DTC_IDX_CTRL, 8'h00);
		wr(DTC_IDX_CH0_FILT, 8'h81);
		@(posedge ref_clk);
		drv <= 8'h01;
		@(posedge ref_clk);
		drv <= 8'h00;
		repeat (12) @(posedge ref_clk);
		#1 chk(fin, 8'h00);
		@(posedge ref_clk);
		drv <= 8'h01;
		repeat (12) @(posedge ref_clk);
		#1 chk(fin, 8'h01);
		wr(DTC_IDX_CH0_FILT, 8'h00);
		@(posedge ref_clk);
		drv <= 8'h00;
		repeat (4) @(posedge ref_clk);
		#1 chk(fin, 8'h00);
		$display("test filter done");
		foreach (pats[j]) begin
			wr(DTC_IDX_CTRL, 8'h00);
			wr(DTC_IDX_CH0_FILT, pats[j]);
			wr(DTC_IDX_CH0_CCC, {DTC_CLR_A, 5'h00});
			wr(DTC_IDX_CTRL, 8'h24);
			@(posedge ref_clk);
			wave <= 8'($urandom);
			cev <= 1'b1;
			@(posedge ref_clk);
			cev <= 1'b0;
			#1;
			for (k = 0; k < 4; k++) begin
				f = {6'h00, pats[j][7 - 2 * k -: 2]};
				if (f == 8'h01) chk({7'h00, poe[k]}, 8'h01);
				if (f[1]) chk({6'h00, poe[k], pout[k]}, {7'h00, f[0]});
				if (f == 8'h00) chk({6'h00, poe[k], pout[k]}, {7'h00, wave[k]});
			end
			chk({poe[7:4], pout[7:4]}, {4'h0, wave[7:4]});
		end
		$display("test cutoff done");
		wrap_up();
	end
endmodule : dual_timer_clock_clear_cutoff_test
bind dtc_top dtc_top_asserts chk_u (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.osc_select_option, .timer_pin_in, .capture_match, .cutoff_event, .count_tick, .counter_clear,
	.filtered_in, .pin_out, .pin_oe_n);
